// >>> pmrs_pkg.sv
`default_nettype none

package pmrs_pkg;
    // Core clock rate
    localparam int CLK_MHZ = 100;
    // Result, calibration, counter, accumulator, timer and period widths
    localparam int SHUNT_W = 16;
    localparam int BUS_W = 16;
    localparam int TEMP_W = 12;
    localparam int CAL_W = 15;
    localparam int PWR_W = 24;
    localparam int CNT_W = 10;
    localparam int ACC_W = 26;
    localparam int TACC_W = 22;
    localparam int TMR_W = 19;
    localparam int PER_W = 23;
    // Conversion times in us, indexed by the conversion-time select
    localparam int CONV_US [8] = '{50, 84, 150, 280, 540, 1052, 2074, 4120};
    // Averaging counts as powers of two: 1, 4, 16, 64, 128, 256, 512, 1024
    localparam int AVG_LOG [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
    // Step sizes per code
    localparam int SHUNT_STEP_NV_WIDE = 5000;
    localparam int SHUNT_STEP_NV_NARROW = 1250;
    localparam int BUS_STEP_UV = 3125;
    localparam int TEMP_STEP_MDEGC = 125;
    // Temperature encoding span in degrees C
    localparam int TEMP_MIN_DEGC = -256;
    localparam int TEMP_MAX_DEGC = 256;
    // Internal scaling shifts of the current and power products
    localparam int CUR_SHIFT = 11;
    localparam int PWR_SHIFT = 8;
    // Saturation limits
    localparam logic signed [31:0] CUR_MAX = 32'sh00007FFF;
    localparam logic signed [31:0] CUR_MIN = -32'sh00008000;
    localparam logic [32:0] PWR_MAX = 33'h000FFFFFF;
endpackage : pmrs_pkg

`default_nettype wire

// >>> pmrs_conv_timer.sv
`timescale 1ns/1ps
`default_nettype none

module pmrs_conv_timer #(
    parameter int CYC_PER_US = pmrs_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Control
    input wire logic i_enable,
    input wire logic [2:0] i_conv_sel,
    // One pulse per finished conversion
    output logic o_tick
);
    logic [pmrs_pkg::TMR_W-1:0] cnt_q, cnt_d;
    logic tick_q, tick_d;
    logic [pmrs_pkg::TMR_W-1:0] limit;

    // Next count; period follows the selected conversion time
    always_comb begin
        limit = pmrs_pkg::TMR_W'(pmrs_pkg::CONV_US[i_conv_sel] * CYC_PER_US - 1);
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!i_enable) begin
            cnt_d = '0;
        end else if (cnt_q >= limit) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    // Register stage
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign o_tick = tick_q;

    // Shortest conversion spans many cycles, so ticks never touch
    property p_tick_gap;
        @(posedge i_core_clk) disable iff (!i_resetn)
        o_tick |=> !o_tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("conversion ticks too close");

endmodule : pmrs_conv_timer

`default_nettype wire

// >>> pmrs_result_scaling.sv
// Function
// - Range bit picks 5 or 1.25 uV step
// - Shunt and bus results 16 bits, shunt signed
// - Bus result never negative, 3.125 mV step
// - Temperature signed 12 bits, 125 mC step
// - Temperature code spans -256 to +256 C
// - Physical value is code times step
// - Current recomputed after shunt result, times calibration
// - Zero calibration gives zero current
// - Power result is 24-bit unsigned
// - Conversion times 50 to 4120 us selectable
// - Sample period is conversion time times averages
`timescale 1ns/1ps
`default_nettype none

module pmrs_result_scaling #(
    parameter int CYC_PER_US = pmrs_pkg::CLK_MHZ
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Configuration
    input wire logic i_enable,
    input wire logic i_shunt_range_select,
    input wire logic [2:0] i_conv_sel,
    input wire logic [2:0] i_avg_sel,
    input wire logic [pmrs_pkg::CAL_W-1:0] i_shunt_cal,
    // Raw samples from the converter, same clock
    input wire logic signed [pmrs_pkg::SHUNT_W-1:0] i_adc_shunt,
    input wire logic signed [pmrs_pkg::BUS_W-1:0] i_adc_bus,
    input wire logic signed [pmrs_pkg::TEMP_W-1:0] i_adc_temp,
    // Front-end range control and sample timing
    output logic o_shunt_range_select,
    output logic o_conv_tick,
    output logic [pmrs_pkg::PER_W-1:0] o_sample_period_us,
    // Results
    output logic signed [pmrs_pkg::SHUNT_W-1:0] o_shunt_voltage_result,
    output logic [pmrs_pkg::BUS_W-1:0] o_bus_voltage_result,
    output logic signed [pmrs_pkg::TEMP_W-1:0] o_die_temperature_result,
    output logic signed [pmrs_pkg::SHUNT_W-1:0] o_current_result,
    output logic [pmrs_pkg::PWR_W-1:0] o_power_result,
    output logic o_result_valid,
    // Results in physical units
    output logic [12:0] o_shunt_step_nv,
    output logic signed [31:0] o_shunt_voltage_nv,
    output logic [31:0] o_bus_voltage_uv,
    output logic signed [19:0] o_die_temperature_mdegc
);
    localparam int SW = pmrs_pkg::SHUNT_W;
    localparam int AW = pmrs_pkg::ACC_W;
    localparam int TW = pmrs_pkg::TACC_W;
    logic tick;
    // Conversion timing
    pmrs_conv_timer #(.CYC_PER_US(CYC_PER_US)) u_timer (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_enable(i_enable),
        .i_conv_sel(i_conv_sel),
        .o_tick(tick)
    );
    // Averaging state
    logic [pmrs_pkg::CNT_W-1:0] cnt_q, cnt_d, last_cnt;
    logic signed [AW-1:0] acc_sh_q, acc_sh_d, sum_sh;
    logic signed [AW-1:0] acc_bu_q, acc_bu_d, sum_bu;
    logic signed [TW-1:0] acc_te_q, acc_te_d, sum_te;
    logic [3:0] avg_log;
    logic first;
    // Averaged results
    logic signed [SW-1:0] sh_q, sh_d;
    logic [pmrs_pkg::BUS_W-1:0] bu_q, bu_d;
    logic signed [pmrs_pkg::TEMP_W-1:0] te_q, te_d;
    logic avg_done_q, avg_done_d;
    logic signed [AW-1:0] avg_bu;

    // Accumulate one sample per tick, divide by the power-of-two count
    always_comb begin
        avg_log = 4'(pmrs_pkg::AVG_LOG[i_avg_sel]);
        last_cnt = pmrs_pkg::CNT_W'((11'h001 << avg_log) - 11'h001);
        first = (cnt_q == '0);
        sum_sh = (first ? '0 : acc_sh_q) + AW'(i_adc_shunt);
        sum_bu = (first ? '0 : acc_bu_q) + AW'(i_adc_bus);
        sum_te = (first ? '0 : acc_te_q) + TW'(i_adc_temp);
        avg_bu = sum_bu >>> avg_log;
        cnt_d = cnt_q;
        acc_sh_d = acc_sh_q;
        acc_bu_d = acc_bu_q;
        acc_te_d = acc_te_q;
        sh_d = sh_q;
        bu_d = bu_q;
        te_d = te_q;
        avg_done_d = 1'b0;
        if (!i_enable) begin
            cnt_d = '0;
        end else if (tick) begin
            acc_sh_d = sum_sh;
            acc_bu_d = sum_bu;
            acc_te_d = sum_te;
            if (cnt_q >= last_cnt) begin
                cnt_d = '0;
                avg_done_d = 1'b1;
                sh_d = SW'(sum_sh >>> avg_log);
                // Offset can push a near-zero bus reading below zero
                bu_d = avg_bu[AW-1] ? '0 : {1'b0, avg_bu[SW-2:0]};
                te_d = pmrs_pkg::TEMP_W'(sum_te >>> avg_log);
            end else begin
                cnt_d = cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt_q <= '0;
            acc_sh_q <= '0;
            acc_bu_q <= '0;
            acc_te_q <= '0;
            sh_q <= '0;
            bu_q <= '0;
            te_q <= '0;
            avg_done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            acc_sh_q <= acc_sh_d;
            acc_bu_q <= acc_bu_d;
            acc_te_q <= acc_te_d;
            sh_q <= sh_d;
            bu_q <= bu_d;
            te_q <= te_d;
            avg_done_q <= avg_done_d;
        end
    end

    // Current, power and physical-unit stage
    logic signed [SW-1:0] cur_q, cur_d;
    logic cur_done_q, cur_done_d;
    logic [pmrs_pkg::PWR_W-1:0] pwr_q, pwr_d;
    logic pwr_done_q, pwr_done_d;
    logic [12:0] step_q, step_d;
    logic signed [31:0] sh_nv_q, sh_nv_d;
    logic [31:0] bu_uv_q, bu_uv_d;
    logic signed [19:0] te_m_q, te_m_d;
    logic signed [31:0] cur_prod, cur_scaled;
    logic [16:0] cur_mag;
    logic [32:0] pwr_prod, pwr_scaled;

    always_comb begin
        cur_prod = 32'(sh_q) * $signed({17'h00000, i_shunt_cal});
        cur_scaled = cur_prod >>> pmrs_pkg::CUR_SHIFT;
        cur_mag = cur_q[SW-1] ? 17'(-{cur_q[SW-1], cur_q}) : {1'b0, cur_q};
        pwr_prod = 33'(cur_mag) * 33'(bu_q);
        pwr_scaled = pwr_prod >> pmrs_pkg::PWR_SHIFT;
        step_d = i_shunt_range_select ? 13'(pmrs_pkg::SHUNT_STEP_NV_NARROW)
                                      : 13'(pmrs_pkg::SHUNT_STEP_NV_WIDE);
        cur_d = cur_q;
        pwr_d = pwr_q;
        sh_nv_d = sh_nv_q;
        bu_uv_d = bu_uv_q;
        te_m_d = te_m_q;
        cur_done_d = avg_done_q;
        pwr_done_d = cur_done_q;
        if (avg_done_q) begin
            // Calibration is read at the moment of each new shunt result
            if (i_shunt_cal == '0) begin
                cur_d = '0;
            end else if (cur_scaled > pmrs_pkg::CUR_MAX) begin
                cur_d = SW'(pmrs_pkg::CUR_MAX);
            end else if (cur_scaled < pmrs_pkg::CUR_MIN) begin
                cur_d = SW'(pmrs_pkg::CUR_MIN);
            end else begin
                cur_d = SW'(cur_scaled);
            end
            sh_nv_d = 32'(sh_q) * $signed({19'h00000, step_q});
            bu_uv_d = 32'(bu_q) * 32'(pmrs_pkg::BUS_STEP_UV);
            te_m_d = 20'(te_q) * 20'(pmrs_pkg::TEMP_STEP_MDEGC);
        end
        if (cur_done_q) begin
            // Saturate rather than wrap when the product overflows
            pwr_d = (pwr_scaled > pmrs_pkg::PWR_MAX) ? '1
                                                     : pmrs_pkg::PWR_W'(pwr_scaled);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cur_q <= '0;
            pwr_q <= '0;
            cur_done_q <= 1'b0;
            pwr_done_q <= 1'b0;
            step_q <= 13'(pmrs_pkg::SHUNT_STEP_NV_WIDE);
            sh_nv_q <= '0;
            bu_uv_q <= '0;
            te_m_q <= '0;
        end else begin
            cur_q <= cur_d;
            pwr_q <= pwr_d;
            cur_done_q <= cur_done_d;
            pwr_done_q <= pwr_done_d;
            step_q <= step_d;
            sh_nv_q <= sh_nv_d;
            bu_uv_q <= bu_uv_d;
            te_m_q <= te_m_d;
        end
    end

    // Sample period registered from the selects
    logic [pmrs_pkg::PER_W-1:0] per_q, per_d;
    logic rng_q, rng_d;
    always_comb begin
        per_d = pmrs_pkg::PER_W'(pmrs_pkg::CONV_US[i_conv_sel]) << avg_log;
        rng_d = i_shunt_range_select;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            per_q <= '0;
            rng_q <= 1'b0;
        end else begin
            per_q <= per_d;
            rng_q <= rng_d;
        end
    end

    // Outputs
    assign o_shunt_range_select = rng_q;
    assign o_conv_tick = tick;
    assign o_sample_period_us = per_q;
    assign o_shunt_voltage_result = sh_q;
    assign o_bus_voltage_result = bu_q;
    assign o_die_temperature_result = te_q;
    assign o_current_result = cur_q;
    assign o_power_result = pwr_q;
    assign o_result_valid = pwr_done_q;
    assign o_shunt_step_nv = step_q;
    assign o_shunt_voltage_nv = sh_nv_q;
    assign o_bus_voltage_uv = bu_uv_q;
    assign o_die_temperature_mdegc = te_m_q;

    // Checks
    property p_step;
        @(posedge i_core_clk) disable iff (!i_resetn)
        ##1 o_shunt_step_nv == ($past(i_shunt_range_select) ? 13'h04E2 : 13'h1388);
    endproperty
    a_step: assert property (p_step) else $error("shunt step does not follow range");

    property p_bus_pos;
        @(posedge i_core_clk) disable iff (!i_resetn)
        avg_done_q |-> !o_bus_voltage_result[15];
    endproperty
    a_bus_pos: assert property (p_bus_pos) else $error("bus result negative");

    property p_temp_span;
        @(posedge i_core_clk) disable iff (!i_resetn)
        cur_done_q |-> (o_die_temperature_mdegc >= -20'sh3E800)
                       && (o_die_temperature_mdegc < 20'sh3E800);
    endproperty
    a_temp_span: assert property (p_temp_span) else $error("temperature out of span");

    property p_phys;
        @(posedge i_core_clk) disable iff (!i_resetn)
        avg_done_q |=> o_bus_voltage_uv == 32'($past(o_bus_voltage_result)) * 32'(pmrs_pkg::BUS_STEP_UV);
    endproperty
    a_phys: assert property (p_phys) else $error("bus physical value wrong");

    property p_cur_after;
        @(posedge i_core_clk) disable iff (!i_resetn)
        tick && (cnt_q >= last_cnt) && i_enable |=> ##1 cur_done_q;
    endproperty
    a_cur_after: assert property (p_cur_after) else $error("current not updated");

    property p_cal_zero;
        @(posedge i_core_clk) disable iff (!i_resetn)
        avg_done_q && (i_shunt_cal == '0) |=> o_current_result == '0;
    endproperty
    a_cal_zero: assert property (p_cal_zero) else $error("current nonzero at zero cal");

    property p_pwr_after;
        @(posedge i_core_clk) disable iff (!i_resetn)
        avg_done_q |=> ##1 o_result_valid ##1 !o_result_valid;
    endproperty
    a_pwr_after: assert property (p_pwr_after) else $error("power not updated");

    property p_pwr_zero;
        @(posedge i_core_clk) disable iff (!i_resetn)
        cur_done_q && (o_current_result == '0) |=> o_power_result == '0;
    endproperty
    a_pwr_zero: assert property (p_pwr_zero) else $error("power nonzero at zero current");

    property p_period;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (i_conv_sel == 3'h0) && (i_avg_sel == 3'h1) |=> o_sample_period_us == 23'h0000C8;
    endproperty
    a_period: assert property (p_period) else $error("sample period wrong");

endmodule : pmrs_result_scaling

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    // Stimulus
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic en = 1'b0;
    logic rng = 1'b0;
    logic [2:0] conv_sel = 3'h0;
    logic [2:0] avg_sel = 3'h0;
    logic [pmrs_pkg::CAL_W-1:0] cal = 15'h0000;
    logic signed [15:0] adc_shunt = 16'h0000;
    logic signed [15:0] adc_bus = 16'h0000;
    logic signed [11:0] adc_temp = 12'h000;
    // Observed outputs
    logic rng_q;
    logic tick;
    logic valid;
    logic [22:0] period;
    logic signed [15:0] shunt_res;
    logic [15:0] bus_res;
    logic signed [11:0] temp_res;
    logic signed [15:0] cur_res;
    logic [23:0] pwr_res;
    logic [12:0] step_nv;
    logic signed [31:0] shunt_nv;
    logic [31:0] bus_uv;
    logic signed [19:0] temp_md;
    int err_count = 0;
    int checks_done = 0;

    // One cycle per microsecond keeps the tested conversions to 50 to 150 cycles
    pmrs_result_scaling #(.CYC_PER_US(1)) uut (
        .i_core_clk(clk), .i_resetn(resetn), .i_enable(en),
        .i_shunt_range_select(rng), .i_conv_sel(conv_sel), .i_avg_sel(avg_sel),
        .i_shunt_cal(cal), .i_adc_shunt(adc_shunt), .i_adc_bus(adc_bus),
        .i_adc_temp(adc_temp), .o_shunt_range_select(rng_q), .o_conv_tick(tick),
        .o_sample_period_us(period), .o_shunt_voltage_result(shunt_res),
        .o_bus_voltage_result(bus_res), .o_die_temperature_result(temp_res),
        .o_current_result(cur_res), .o_power_result(pwr_res), .o_result_valid(valid),
        .o_shunt_step_nv(step_nv), .o_shunt_voltage_nv(shunt_nv),
        .o_bus_voltage_uv(bus_uv), .o_die_temperature_mdegc(temp_md)
    );

    // Clock
    always #5 clk = ~clk;

    // Compare and count
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Sync to one pulse, then count cycles to the next; bounded against a hang
    task automatic gap(input bit use_valid, output int n);
        n = 0;
        while ((use_valid ? valid : tick) !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((use_valid ? valid : tick) !== 1'b1 && n < 5000);
    endtask

    // Values held while reset is low
    task automatic t_reset();
        chk("step_rst", {19'h0, step_nv}, pmrs_pkg::SHUNT_STEP_NV_WIDE);
        chk("cur_rst", {16'h0, cur_res}, 32'h0);
        chk("pwr_rst", {8'h0, pwr_res}, 32'h0);
        chk("valid_rst", {31'h0, valid}, 32'h0);
    endtask

    // Every conversion time against every averaging count
    task automatic t_period();
        int exp_p;
        for (int c = 0; c < 8; c++) begin
            for (int a = 0; a < 8; a++) begin
                conv_sel = c[2:0];
                avg_sel = a[2:0];
                repeat (2) @(negedge clk);
                exp_p = pmrs_pkg::CONV_US[c] << pmrs_pkg::AVG_LOG[a];
                chk("period", {9'h0, period}, exp_p);
            end
        end
        conv_sel = 3'h0;
        avg_sel = 3'h0;
    endtask

    // Tick spacing follows the selected conversion time
    task automatic t_tick();
        int n;
        for (int c = 0; c < 3; c++) begin
            conv_sel = c[2:0];
            gap(1'b0, n);
            gap(1'b0, n);
            chk("tick_gap", n, pmrs_pkg::CONV_US[c]);
        end
        // Switch back just after a tick so the count is still low
        conv_sel = 3'h0;
    endtask

    // Drive steady samples, skip a mixed result, judge a clean one
    task automatic t_meas(input logic r, input logic [14:0] c, input logic signed [15:0] s,
                          input logic signed [15:0] b, input logic signed [11:0] t);
        longint cur;
        longint bus_e;
        longint pwr;
        int n;
        int step;
        rng = r;
        cal = c;
        adc_shunt = s;
        adc_bus = b;
        adc_temp = t;
        gap(1'b1, n);
        gap(1'b1, n);
        chk("valid_seen", {31'h0, valid}, 32'h1);
        step = r ? pmrs_pkg::SHUNT_STEP_NV_NARROW : pmrs_pkg::SHUNT_STEP_NV_WIDE;
        cur = (longint'(s) * longint'(c)) >>> pmrs_pkg::CUR_SHIFT;
        cur = (cur > 32767) ? 32767 : ((cur < -32768) ? -32768 : cur);
        bus_e = (b < 0) ? 0 : longint'(b);
        pwr = (((cur < 0) ? -cur : cur) * bus_e) >> pmrs_pkg::PWR_SHIFT;
        pwr = (pwr > 64'hFFFFFF) ? 64'hFFFFFF : pwr;
        chk("range_q", {31'h0, rng_q}, {31'h0, r});
        chk("step", {19'h0, step_nv}, step);
        chk("shunt", shunt_res, s);
        chk("bus", {16'h0, bus_res}, 32'(bus_e));
        chk("temp", temp_res, t);
        chk("temp_mdegc", temp_md, t * pmrs_pkg::TEMP_STEP_MDEGC);
        chk("shunt_nv", shunt_nv, s * step);
        chk("bus_uv", bus_uv, 32'(bus_e * pmrs_pkg::BUS_STEP_UV));
        chk("current", cur_res, 32'(cur));
        chk("power", {8'h0, pwr_res}, 32'(pwr));
    endtask

    // Four-sample averaging stretches the result period fourfold
    task automatic t_avg();
        int n;
        avg_sel = 3'h1;
        gap(1'b1, n);
        gap(1'b1, n);
        chk("avg_gap", n, 4 * pmrs_pkg::CONV_US[0]);
        t_meas(1'b0, 15'h0400, -16'sh0123, 16'h0456, 12'sh03C);
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge clk);
        t_reset();
        resetn = 1'b1;
        t_period();
        en = 1'b1;
        t_tick();
        t_meas(1'b0, 15'h0800, -16'sh0100, 16'h1000, -12'sh0A0);
        t_meas(1'b1, 15'h0123, 16'h1234, 16'h7FFF, 12'sh7FF);
        t_meas(1'b0, 15'h0000, 16'h4000, 16'h2000, -12'sh800);
        // Full-scale shunt pins current at the 2^15 - 1 code limit the host sizes for
        t_meas(1'b0, 15'h7FFF, 16'h7FFF, 16'h7FFF, 12'sh000);
        // Narrow range: host calibration is four times the first wide-range one
        t_meas(1'b1, 15'h2000, -16'sh8000, -16'sh0005, 12'sh001);
        t_avg();
        close_out();
    end

    // Watchdog: the sequence needs well under 10000 cycles
    initial begin
        #(400000);
        err_count++;
        close_out();
    end
endmodule // tb

`default_nettype wire
